// ### core/scwp_top.sv
// Serial control word port: three-wire write-only receiver of a 16-bit
// control word plus an AHB-Lite register view.
// Assumes the serial pins are asynchronous to hclk and far slower than it.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Word arrives least significant bit first; bit i lands in position i.
// - Data line is sampled on each rising serial clock edge.
// - Enable dropping before sixteen bits discards the partial word.
// - Only first sixteen bits kept; applied at the sixteenth rising edge.
// - Bit 0 is active-low converter reset; all word bits reset to zero.
// - Bits 2:1 choose shutdown, standby, mute or active.
// - Bits 11:7 give 32-step volume, -43.5 dB plus 1.5 dB steps.
// - Bits 3,4,6,12 set master, 32-bit, zero-cross off, fast charge.
module scwp_top
  import scwp_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Serial control pins
  input wire logic ctl_sclk,
  input wire logic ctl_sdata,
  input wire logic ctl_enable,
  // Applied control settings
  output logic [15:0] ctl_word,
  output logic dac_reset_n,
  output logic [1:0] power_mode,
  output logic full_shutdown_mode,
  output logic clock_master,
  output logic sample_32bit,
  output logic zero_cross_gating,
  output logic [4:0] volume,
  output logic bias_charge_speed
);
  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [2:0] pins_s;
  logic sclk_s, data_s, en_s, sclk_d, sclk_rise;

  scwp_sync #(.WIDTH(3)) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .din({ctl_enable, ctl_sdata, ctl_sclk}),
    .dout(pins_s)
  );
  assign sclk_s = pins_s[0];
  assign data_s = pins_s[1];
  assign en_s = pins_s[2];
  // Clock and data share one pipeline depth, so they stay aligned
  assign sclk_rise = sclk_s & ~sclk_d;

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  scwp_state_t state, next_state;
  logic [SCWP_CNT_W-1:0] bit_cnt, next_bit_cnt;
  logic [15:0] sreg, next_sreg, word, next_word;
  logic shut, next_shut;
  logic [7:0] word_cnt, next_word_cnt;
  logic port_en, take_bit, last_bit;

  assign take_bit = sclk_rise & (state == SCWP_ST_SHIFT);
  assign last_bit = take_bit & (bit_cnt == SCWP_CNT_W'(SCWP_WORD_BITS - 1));

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_sreg = sreg;
    next_word = word;
    next_shut = shut;
    next_word_cnt = word_cnt;
    case (state)
      SCWP_ST_IDLE: begin
        // Enable is sampled high only after setup, so no bit is lost
        if (en_s && port_en) begin
          next_state = SCWP_ST_SHIFT;
        end
      end
      SCWP_ST_SHIFT: begin
        if (take_bit) begin
          next_sreg[bit_cnt[3:0]] = data_s;
          next_bit_cnt = bit_cnt + SCWP_CNT_W'(1);
        end
        if (last_bit) begin
          next_word = {data_s, sreg[SCWP_WORD_BITS-2:0]};
          next_shut = (next_word[SCWP_B_MODE_HI:SCWP_B_MODE_LO] == SCWP_MODE_SHUTDOWN);
          next_word_cnt = word_cnt + 8'h01;
          next_state = SCWP_ST_HOLD;
        end
      end
      SCWP_ST_HOLD: begin
        // Extra clock pulses are ignored until enable drops
        next_state = SCWP_ST_HOLD;
      end
      default: next_state = SCWP_ST_IDLE;
    endcase
    // A sampled low lasts at least one cycle, longer than the abort time
    if (!en_s) begin
      next_state = SCWP_ST_IDLE;
      next_bit_cnt = '0;
      next_sreg = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= SCWP_ST_IDLE;
      bit_cnt <= '0;
      sreg <= '0;
      word <= SCWP_WORD_RESET;
      shut <= 1'b1;
      word_cnt <= 8'h00;
      sclk_d <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      sreg <= next_sreg;
      word <= next_word;
      shut <= next_shut;
      word_cnt <= next_word_cnt;
      sclk_d <= sclk_s;
    end
  end

  assign ctl_word = word;
  assign dac_reset_n = word[SCWP_B_RESET_N];
  assign power_mode = word[SCWP_B_MODE_HI:SCWP_B_MODE_LO];
  assign full_shutdown_mode = shut;
  assign clock_master = word[SCWP_B_MASTER];
  assign sample_32bit = word[SCWP_B_RES32];
  assign volume = word[SCWP_B_VOL_HI:SCWP_B_VOL_LO];
  assign bias_charge_speed = word[SCWP_B_CHARGE];

  // Bit 6 set means gating is switched off
  logic zx_gate;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      zx_gate <= 1'b1;
    end else begin
      zx_gate <= ~next_word[SCWP_B_ZX_OFF];
    end
  end
  assign zero_cross_gating = zx_gate;

  // ----------------------------------------------------------------
  // AHB-Lite register slave
  // ----------------------------------------------------------------
  logic [31:0] cfg, next_cfg, next_hrdata;
  logic wr_pend, next_wr_pend;
  logic [7:0] wr_addr, next_wr_addr;
  logic accept;

  function automatic logic [31:0] scwp_read(input logic [7:0] a, input logic [15:0] w,
                                            input logic [31:0] st, input logic [31:0] c);
    if (a == SCWP_OFS_WORD) begin
      scwp_read = {16'h0000, w};
    end else if (a == SCWP_OFS_STATUS) begin
      scwp_read = st;
    end else if (a == SCWP_OFS_CFG) begin
      scwp_read = c;
    end else begin
      scwp_read = 32'h0000_0000;
    end
  endfunction

  logic [31:0] status;
  always_comb begin
    status = 32'h0000_0000;
    status[SCWP_ST_CNT_LO +: SCWP_CNT_W] = bit_cnt;
    status[SCWP_ST_EN] = en_s;
    // Host is expected to send bit 5 high and bits 15:13 low
    status[SCWP_ST_BADRSV] = (word[SCWP_B_RSV_HI:SCWP_B_RSV_LO] != 3'h0) | ~word[SCWP_B_MUST_ONE];
    status[SCWP_ST_WCNT_LO +: 8] = word_cnt;
  end

  assign port_en = cfg[SCWP_CFG_PORT_EN];
  assign accept = hsel & hready & htrans[1];

  always_comb begin
    next_cfg = cfg;
    next_wr_pend = accept & hwrite;
    next_wr_addr = accept ? haddr : wr_addr;
    next_hrdata = hrdata;
    if (wr_pend && wr_addr == SCWP_OFS_CFG) begin
      next_cfg = {31'h0000_0000, hwdata[SCWP_CFG_PORT_EN]};
    end
    // Read data are prepared at the address phase: zero wait states
    if (accept && !hwrite) begin
      next_hrdata = scwp_read(haddr, word, status, cfg);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= SCWP_CFG_RESET;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      cfg <= next_cfg;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_idle_clears: assert property (!en_s |=> bit_cnt == '0 && sreg == '0)
    else $error("bit counter not cleared while enable low");
  chk_partial_drop: assert property (!last_bit |=> $stable(word))
    else $error("word changed without a sixteenth bit");
  chk_lsb_first: assert property (last_bit |=> word == {$past(data_s), $past(sreg[14:0])})
    else $error("word not assembled lsb first");
  chk_bit_step: assert property (take_bit && en_s |=> bit_cnt == $past(bit_cnt) + 5'h01)
    else $error("bit counter did not step on clock rise");
  chk_count_cap: assert property (bit_cnt <= 5'h10)
    else $error("bit counter beyond sixteen");
  chk_hold_ignores: assert property (state == SCWP_ST_HOLD && en_s |=> state == SCWP_ST_HOLD && $stable(word))
    else $error("extra pulses altered the word");
  chk_shutdown_decode: assert property (full_shutdown_mode == (power_mode == SCWP_MODE_SHUTDOWN))
    else $error("shutdown flag disagrees with mode");
  chk_zero_cross: assert property (zero_cross_gating == ~word[SCWP_B_ZX_OFF])
    else $error("zero cross gating disagrees with word");
  chk_volume_field: assert property (last_bit |=> volume == $past(sreg[11:7]))
    else $error("volume not taken from bits 11 to 7");
  chk_reset_bit: assert property (last_bit |=> dac_reset_n == $past(sreg[0]))
    else $error("converter reset not taken from bit 0");

  cov_word_applied: cover property (last_bit ##1 dac_reset_n && power_mode == SCWP_MODE_ACTIVE);
  cov_aborted: cover property (state == SCWP_ST_SHIFT && bit_cnt != 5'h00 && !en_s);
  cov_extra_pulses: cover property (state == SCWP_ST_HOLD && sclk_rise);
  cov_cfg_read: cover property (accept && !hwrite && haddr == SCWP_OFS_CFG);
endmodule
`default_nettype wire

// ### core/scwp_pkg.sv
// Package for the serial control word port: register map, word layout,
// reset values and timing figures.
// Assumes a 25 MHz bus clock and an AHB-Lite master with 32-bit data.
package scwp_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] SCWP_OFS_WORD = 8'h00;
  localparam logic [7:0] SCWP_OFS_STATUS = 8'h04;
  localparam logic [7:0] SCWP_OFS_CFG = 8'h08;
  localparam logic [31:0] SCWP_CFG_RESET = 32'h0000_0001;
  localparam int SCWP_CFG_PORT_EN = 0;
  // ----------------------------------------------------------------
  // Control word layout
  // ----------------------------------------------------------------
  localparam int SCWP_WORD_BITS = 16;
  localparam int SCWP_CNT_W = 5;
  localparam logic [15:0] SCWP_WORD_RESET = 16'h0000;
  localparam int SCWP_B_RESET_N = 0;
  localparam int SCWP_B_MODE_LO = 1;
  localparam int SCWP_B_MODE_HI = 2;
  localparam int SCWP_B_MASTER = 3;
  localparam int SCWP_B_RES32 = 4;
  localparam int SCWP_B_MUST_ONE = 5;
  localparam int SCWP_B_ZX_OFF = 6;
  localparam int SCWP_B_VOL_LO = 7;
  localparam int SCWP_B_VOL_HI = 11;
  localparam int SCWP_B_CHARGE = 12;
  localparam int SCWP_B_RSV_LO = 13;
  localparam int SCWP_B_RSV_HI = 15;
  // Output power modes
  localparam logic [1:0] SCWP_MODE_SHUTDOWN = 2'h0;
  localparam logic [1:0] SCWP_MODE_STANDBY = 2'h1;
  localparam logic [1:0] SCWP_MODE_MUTE = 2'h2;
  localparam logic [1:0] SCWP_MODE_ACTIVE = 2'h3;
  // Status fields
  localparam int SCWP_ST_CNT_LO = 0;
  localparam int SCWP_ST_EN = 8;
  localparam int SCWP_ST_BADRSV = 9;
  localparam int SCWP_ST_WCNT_LO = 16;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SCWP_HCLK_NS = 40;
  localparam int SCWP_ABORT_NS = 10;
  // Longest time rounds down, never below one cycle
  localparam int SCWP_ABORT_CYC = (SCWP_ABORT_NS / SCWP_HCLK_NS) < 1 ? 1 : (SCWP_ABORT_NS / SCWP_HCLK_NS);
  // ----------------------------------------------------------------
  // Receiver states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SCWP_ST_IDLE = 3'b001,
    SCWP_ST_SHIFT = 3'b010,
    SCWP_ST_HOLD = 3'b100
  } scwp_state_t;
endpackage

// ### core/scwp_sync.sv
// Two-flop synchroniser for pin inputs of the serial control word port.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module scwp_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
`default_nettype wire

// ### testbench/scwp_host.sv
// Host model for the serial control word port: drives clock, data, enable.
// Assumes one caller at a time; each send ends with the link idle.
`timescale 1ns/1ps
`default_nettype none
module scwp_host (
  // Serial pins
  output logic sclk,
  output logic sdata,
  output logic enable
);
  // 320 ns period keeps the link well under 5 MHz
  localparam int HALF = 160;
  initial begin
    sclk = 1'b0;
    sdata = 1'b1;
    enable = 1'b0;
  end
  // Pulses past sixteen carry junk that the device has to drop
  task automatic send(input logic [15:0] w, input int npulse, input logic [3:0] junk);
    #13;
    enable <= 1'b1;
    #(HALF);
    for (int i = 0; i < npulse; i++) begin
      sdata <= (i < 16) ? w[i] : junk[i % 4];
      #(HALF) sclk <= 1'b1;
      #(HALF) sclk <= 1'b0;
    end
    // Enable falls half way into the low phase, never on a clock edge
    #(HALF / 2) enable <= 1'b0;
    sdata <= ~sdata;
    // Clock is already low when enable next rises
    #(2 * HALF);
  endtask
endmodule
`default_nettype wire

// ### testbench/scwp_top_tb.sv
// Self-checking bench for the serial control word port.
// Assumes the host model drives the serial pins; bus is AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module scwp_top_tb;
  import scwp_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans, power_mode;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd, seed;
  wire logic ctl_sclk, ctl_sdata, ctl_enable;
  logic [15:0] ctl_word, w;
  logic dac_reset_n, full_shutdown_mode, clock_master, sample_32bit, zero_cross_gating, bias_charge_speed;
  logic [4:0] volume;
  int failures, comparisons, exp_word, exp_cnt;

  scwp_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .ctl_sclk, .ctl_sdata, .ctl_enable, .ctl_word, .dac_reset_n, .power_mode,
    .full_shutdown_mode, .clock_master, .sample_32bit, .zero_cross_gating, .volume, .bias_charge_speed);
  scwp_host host (.sclk(ctl_sclk), .sdata(ctl_sdata), .enable(ctl_enable));

  always #20 hclk = ~hclk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic report_and_stop();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic fail(input string m);
    failures++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) fail(m);
  endtask
  // Every applied output against the model word
  task automatic cmp_fields();
    cmp32({16'h0, ctl_word}, exp_word, "applied word");
    cmp32({19'h0, dac_reset_n, power_mode, full_shutdown_mode, clock_master, sample_32bit, zero_cross_gating,
      volume, bias_charge_speed}, {19'h0, exp_word[0], exp_word[2:1], exp_word[2:1] == 2'h0, exp_word[3],
      exp_word[4], ~exp_word[6], exp_word[11:7], exp_word[12]}, "decoded fields");
  endtask
  // Single transfer; call just after a rising edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 32);
    rd = hrdata;
    if (hreadyout !== 1'b1) begin
      fail("bus wait ran out");
      report_and_stop();
    end
    cmp32({31'h0, hresp}, 32'h0, "response");
  endtask
  // Idle status: counter cleared, enable low, reserved-bit flag from the model word
  task automatic cmp_status();
    logic bad;
    bad = (exp_word[15:13] != 3'h0) | ~exp_word[5];
    cmp32(rd, {8'h00, exp_cnt[7:0], 6'h00, bad, 1'b0, 3'h0, 5'h00}, "status");
  endtask
  task automatic word(input logic [15:0] v, input int np, input logic take);
    seed = xs(seed);
    host.send(v, np, seed[3:0]);
    if (take) begin
      exp_word = v;
      exp_cnt++;
    end
    @(posedge hclk);
    cmp_fields();
  endtask

  initial begin
    #3000000;
    fail("run timeout");
    report_and_stop();
  end

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    {failures, comparisons, exp_word, exp_cnt} = '0;
    seed = 32'h72A4;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    cmp_fields();
    ahb(1'b0, SCWP_OFS_CFG, 32'h0);
    cmp32(rd, SCWP_CFG_RESET, "cfg reset");
    ahb(1'b0, SCWP_OFS_STATUS, 32'h0);
    cmp_status();
    ahb(1'b1, SCWP_OFS_WORD, 32'hFFFF);
    ahb(1'b0, 8'h0C, 32'h0);
    cmp32(rd, 32'h0, "unmapped read");
    ahb(1'b0, SCWP_OFS_WORD, 32'h0);
    cmp32(rd, 32'h0, "read-only word");
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      w = (seed[15:0] & 16'h1FDF) | 16'h0020;
      w[2:1] = i[1:0];
      if (i == 3) w[0] = 1'b1;
      if (i == 4) w[11:7] = 5'h00;
      if (i == 5) w[11:7] = 5'h1F;
      word(w, 16, 1'b1);
      ahb(1'b0, SCWP_OFS_WORD, 32'h0);
      cmp32(rd, exp_word, "word register");
    end
    word(~w & 16'h1FDF | 16'h0020, 9, 1'b0);
    word(w ^ 16'h0F87, 16, 1'b1);
    word(w ^ 16'h1001, 20, 1'b1);
    ahb(1'b1, SCWP_OFS_CFG, 32'h0);
    word(w ^ 16'h0006, 16, 1'b0);
    ahb(1'b1, SCWP_OFS_CFG, 32'h1);
    ahb(1'b0, SCWP_OFS_STATUS, 32'h0);
    cmp32({24'h0, rd[23:16]}, exp_cnt, "applied count");
    cmp_status();
    report_and_stop();
  end
endmodule
`default_nettype wire
